// ---- hw/uart_ctrl_pkg.sv ----
package uart_ctrl_pkg;

	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_DATA = 4'h0;
	localparam logic [3:0] IDX_IRQ_ENABLE = 4'h1;
	localparam logic [3:0] IDX_IRQ_IDENTIFY = 4'h2;
	localparam logic [3:0] IDX_LINE_FORMAT = 4'h3;
	localparam logic [3:0] IDX_HANDSHAKE = 4'h4;
	localparam int ADDR_W = 6;
	localparam int IDX_LSB = 2;

	// Line format fields
	localparam int LF_LEN_LSB = 0;
	localparam int LF_STOP = 2;
	localparam int LF_PAR_EN = 3;
	localparam int LF_EVEN = 4;
	localparam int LF_STICK = 5;
	localparam int LF_BREAK = 6;
	localparam int LF_DIV_ACCESS = 7;

	// Handshake control fields
	localparam int HC_TERM_READY = 0;
	localparam int HC_SEND_REQ = 1;
	localparam int HC_AUX_ONE = 2;
	localparam int HC_IRQ_GATE = 3;
	localparam int HC_LOOPBACK = 4;
	localparam int HC_W = 5;

	// Interrupt enable fields
	localparam int IE_RX_DATA = 0;
	localparam int IE_THR_EMPTY = 1;
	localparam int IE_LINE_STATUS = 2;
	localparam int IE_MODEM = 3;
	localparam int IE_W = 4;

	// Identification codes, bits 3..0
	localparam logic [3:0] ID_NONE = 4'h1;
	localparam logic [3:0] ID_LINE_STATUS = 4'h6;
	localparam logic [3:0] ID_RX_DATA = 4'h4;
	localparam logic [3:0] ID_CHAR_TIMEOUT = 4'hc;
	localparam logic [3:0] ID_THR_EMPTY = 4'h2;
	localparam logic [3:0] ID_MODEM = 4'h0;

	// Reset values
	localparam logic [7:0] LINE_FORMAT_RESET = 8'h00;
	localparam logic [HC_W-1:0] HANDSHAKE_RESET = 5'h00;
	localparam logic [IE_W-1:0] IRQ_ENABLE_RESET = 4'h0;
	localparam logic [15:0] DIVISOR_RESET = 16'h0000;

	// Character timing in 16x baud ticks
	localparam logic [9:0] TICKS_PER_BIT = 10'h010;
	localparam logic [9:0] TICKS_HALF_BIT = 10'h008;
	localparam logic [9:0] START_AND_BASE_BITS = 10'h006;
	localparam logic [1:0] TIMEOUT_CHARS_LOG2 = 2'h2;
	localparam logic [4:0] RX_LEVEL_ONE = 5'h01;
	localparam logic [4:0] RX_LEVEL_FOUR = 5'h04;
	localparam logic [4:0] RX_LEVEL_EIGHT = 5'h08;
	localparam logic [4:0] RX_LEVEL_FOURTEEN = 5'h0e;

	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic		break_on;
		logic		stick;
		logic		even;
		logic		parity_en;
		logic		two_stop;
		logic [1:0]	word_len;
	} line_cfg_s;

	typedef struct packed {
		logic	carrier;
		logic	ring;
		logic	set_ready;
		logic	clear_to_send;
	} modem_s;

endpackage

// ---- hw/uart_irq_line_modem.sv ----
// How it works
// (RULE1) Pending sources ranked: line status, data or timeout, holding empty, modem status.
// (RULE2) Identification value frozen while a host read of it is under way.
// (RULE3) Identification bit 0 is low when something is pending, high otherwise.
// (RULE4) Bits 3..1 give 011, 010, 110, 001 or 000 for the top source.
// (RULE5) Bit 3 only set, with bit 2, for character timeout in FIFO mode.
// (RULE6) Bits 7 and 6 both follow FIFO enable.
// (RULE7) FIFO timeout after four idle character times with data; receive read clears.
// (RULE8) Data available drops on buffer read or level under trigger.
// (RULE9) Holding empty cleared by identification read naming it, or holding write.
// (RULE10) Line format bits 1..0 pick five to eight data bits.
// (RULE11) Bit 2 picks one stop bit, else 1.5 for five bits or two.
// (RULE12) Receiver checks only the first stop bit.
// (RULE13) Bit 3 enables a parity bit after data, before stop.
// (RULE14) Bit 4 low gives odd parity, high gives even parity.
// (RULE15) Stick parity sends and checks inverse of bit 4 as constant.
// (RULE16) Bit 6 forces serial output to zero while set.
// (RULE17) Bit 7 steers offsets 0 and 1 to divisor latches; software clears it.
// (RULE18) Offset 0 is receive/transmit data, offset 1 interrupt enable, else divisor.
// (RULE19) Handshake bits 0 and 1 drive terminal ready and send request inverted.
// (RULE20) Handshake bit 2 is plain storage feeding loopback only.
// (RULE21) Handshake bit 3 enables the interrupt output driver.
// (RULE22) Loopback: serial output marks, input ignored, transmit feeds receive.
// (RULE23) Loopback: modem pins cut, outputs high, control bits feed status inputs.
// (RULE24) Loopback modem interrupts come from control bits, still enable gated.
// (RULE25) Handshake bits 7..5 and identification bits 5..4 read zero.
// (RULE26) Identification recomputed every cycle except during the read freeze.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module uart_irq_line_modem (
	input  wire logic                            clk,
	input  wire logic                            reset_n,
	input  wire logic [uart_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                            s_axi_awvalid,
	output logic                                 s_axi_awready,
	input  wire logic [31:0]                     s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output logic                                 s_axi_wready,
	output logic [1:0]                           s_axi_bresp,
	output logic                                 s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	input  wire logic [uart_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                            s_axi_arvalid,
	output logic                                 s_axi_arready,
	output logic [31:0]                          s_axi_rdata,
	output logic [1:0]                           s_axi_rresp,
	output logic                                 s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	input  wire logic                            fifo_enable,
	input  wire logic [1:0]                      rx_trigger_sel,
	input  wire logic [4:0]                      rx_level,
	input  wire logic                            rx_push,
	input  wire logic [7:0]                      rx_buffer_data,
	output logic                                 rx_buffer_read,
	output logic                                 thr_write,
	output logic [7:0]                           thr_data,
	input  wire logic                            thr_empty,
	input  wire logic                            line_status_event,
	input  wire logic                            modem_delta,
	input  wire logic                            baud16_tick,
	output logic [15:0]                          divisor,
	output uart_ctrl_pkg::line_cfg_s             line_cfg,
	input  wire logic                            tx_shift_out,
	output logic                                 rx_shift_in,
	output logic                                 serial_out,
	input  wire logic                            serial_in,
	output logic                                 terminal_ready_n,
	output logic                                 send_request_n,
	input  wire logic                            clear_to_send_n,
	input  wire logic                            set_ready_n,
	input  wire logic                            ring_indicate_n,
	input  wire logic                            carrier_detect_n,
	output uart_ctrl_pkg::modem_s                modem_status,
	output logic                                 irq_out,
	output logic                                 irq_oe
);
	import uart_ctrl_pkg::*;

	function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[ADDR_W-1:IDX_LSB];
	endfunction

	// One character in 16x ticks: start + data + parity + stop
	function automatic logic [9:0] char_ticks(input logic [7:0] lf);
		logic [9:0] bits;
		logic [9:0] stop;
		bits = START_AND_BASE_BITS + {8'h00, lf[LF_LEN_LSB +: 2]} + {9'h000, lf[LF_PAR_EN]};
		stop = TICKS_PER_BIT;
		if (lf[LF_STOP]) begin
			stop = (lf[LF_LEN_LSB +: 2] == 2'b00) ? TICKS_PER_BIT + TICKS_HALF_BIT : TICKS_PER_BIT + TICKS_PER_BIT;
		end
		char_ticks = (bits - START_AND_BASE_BITS + 10'h006) * TICKS_PER_BIT + stop;
	endfunction

	logic [7:0]       line_format_q;
	logic [HC_W-1:0]  handshake_q;
	logic [IE_W-1:0]  irq_enable_q;
	logic [15:0]      divisor_q;
	logic [7:0]       irq_identify_q;
	logic             thre_pend_q;
	logic             thre_src_q;
	logic             timeout_q;
	logic [9:0]       idle_cnt_q;
	logic             aw_have_q;
	logic             w_have_q;
	logic [3:0]       aw_idx_q;
	logic [7:0]       w_data_q;
	logic             w_strb_q;
	logic             bvalid_q;
	logic [1:0]       bresp_q;
	logic             rvalid_q;
	logic [7:0]       rdata_q;
	logic [1:0]       rresp_q;
	logic             rd_iir_q;
	logic             rx_read_q;
	logic             thr_write_q;
	logic [7:0]       thr_data_q;

	// Bus decode
	wire        divisor_access_select        = line_format_q[LF_DIV_ACCESS];
	wire        loopback    = handshake_q[HC_LOOPBACK];
	wire        ar_take     = s_axi_arvalid & s_axi_arready;
	wire [3:0]  ar_idx      = reg_index(s_axi_araddr);
	wire        wr_fire     = aw_have_q & w_have_q & ~bvalid_q;
	wire        wr_lane     = wr_fire & w_strb_q;
	wire        wr_data     = wr_lane & (aw_idx_q == IDX_DATA);
	wire        wr_ie       = wr_lane & (aw_idx_q == IDX_IRQ_ENABLE);
	wire        wr_thr      = wr_data & ~divisor_access_select; // RULE18
	wire        wr_dll      = wr_data & divisor_access_select; // RULE17
	wire        wr_ier      = wr_ie & ~divisor_access_select; // RULE18
	wire        wr_dlm      = wr_ie & divisor_access_select; // RULE17
	wire        wr_lf       = wr_lane & (aw_idx_q == IDX_LINE_FORMAT);
	wire        wr_hc       = wr_lane & (aw_idx_q == IDX_HANDSHAKE);
	wire        wr_known    = (aw_idx_q <= IDX_HANDSHAKE) & (aw_idx_q != IDX_IRQ_IDENTIFY);
	wire        rd_rbr      = ar_take & (ar_idx == IDX_DATA) & ~divisor_access_select; // RULE18
	wire        rd_iir      = ar_take & (ar_idx == IDX_IRQ_IDENTIFY);
	wire        rd_known    = ar_idx <= IDX_HANDSHAKE;

	// Interrupt sources
	wire [4:0]  trig_level  = (rx_trigger_sel == 2'b00) ? RX_LEVEL_ONE :
				  (rx_trigger_sel == 2'b01) ? RX_LEVEL_FOUR :
				  (rx_trigger_sel == 2'b10) ? RX_LEVEL_EIGHT : RX_LEVEL_FOURTEEN;
	wire        rx_has_data = rx_level != 5'h00;
	// Level based, so a read that drains below trigger removes it
	wire        rx_avail    = fifo_enable ? (rx_level >= trig_level) : rx_has_data; // RULE8
	wire        src_ls      = line_status_event & irq_enable_q[IE_LINE_STATUS];
	wire        src_rx      = rx_avail & irq_enable_q[IE_RX_DATA];
	wire        src_to      = timeout_q & irq_enable_q[IE_RX_DATA];
	wire        src_thre    = thre_pend_q & irq_enable_q[IE_THR_EMPTY];
	wire        src_ms      = modem_delta & irq_enable_q[IE_MODEM]; // RULE24
	wire [3:0]  id_code     = src_ls ? ID_LINE_STATUS : // RULE1 RULE4
				  src_rx ? ID_RX_DATA :
				  src_to ? (fifo_enable ? ID_CHAR_TIMEOUT : ID_RX_DATA) : // RULE5
				  src_thre ? ID_THR_EMPTY :
				  src_ms ? ID_MODEM : ID_NONE; // RULE3
	wire [7:0]  id_next     = {fifo_enable, fifo_enable, 2'b00, id_code}; // RULE6 RULE25
	wire        iir_frozen  = rd_iir | (rvalid_q & rd_iir_q); // RULE2
	wire        thre_named  = rd_iir & (irq_identify_q[3:0] == ID_THR_EMPTY);
	wire        idle_event  = rx_push | rx_read_q | ~rx_has_data | ~fifo_enable;
	wire [9:0]  idle_limit  = char_ticks(line_format_q) << TIMEOUT_CHARS_LOG2;
	wire        idle_done   = baud16_tick & (idle_cnt_q >= idle_limit - 10'h001);

	// Read mux
	wire [7:0]  rd_mux      = (ar_idx == IDX_DATA) ? (divisor_access_select ? divisor_q[7:0] : rx_buffer_data) :
				  (ar_idx == IDX_IRQ_ENABLE) ? (divisor_access_select ? divisor_q[15:8] : {4'h0, irq_enable_q}) :
				  (ar_idx == IDX_IRQ_IDENTIFY) ? irq_identify_q :
				  (ar_idx == IDX_LINE_FORMAT) ? line_format_q :
				  (ar_idx == IDX_HANDSHAKE) ? {3'b000, handshake_q} : 8'h00; // RULE25

	// Bus handshakes
	assign s_axi_awready = ~aw_have_q;
	assign s_axi_wready  = ~w_have_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = {24'h000000, rdata_q};
	assign s_axi_rresp   = rresp_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_idx_q  <= 4'h0;
			w_data_q  <= 8'h00;
			w_strb_q  <= 1'b0;
		end else begin
			aw_have_q <= (aw_have_q & ~wr_fire) | (s_axi_awvalid & ~aw_have_q);
			w_have_q  <= (w_have_q & ~wr_fire) | (s_axi_wvalid & ~w_have_q);
			if (s_axi_awvalid & ~aw_have_q) begin
				aw_idx_q <= reg_index(s_axi_awaddr);
			end
			if (s_axi_wvalid & ~w_have_q) begin
				w_data_q <= s_axi_wdata[7:0];
				w_strb_q <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= AXI_OKAY;
			rvalid_q <= 1'b0;
			rdata_q  <= 8'h00;
			rresp_q  <= AXI_OKAY;
			rd_iir_q <= 1'b0;
		end else begin
			bvalid_q <= wr_fire | (bvalid_q & ~s_axi_bready);
			if (wr_fire) begin
				bresp_q <= wr_known ? AXI_OKAY : AXI_SLVERR;
			end
			rvalid_q <= ar_take | (rvalid_q & ~s_axi_rready);
			if (ar_take) begin
				rdata_q  <= rd_mux;
				rresp_q  <= rd_known ? AXI_OKAY : AXI_SLVERR;
				rd_iir_q <= rd_iir;
			end
		end
	end

	// Software registers; narrow writes through byte lane 0 only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			line_format_q <= LINE_FORMAT_RESET;
			handshake_q   <= HANDSHAKE_RESET;
			irq_enable_q  <= IRQ_ENABLE_RESET;
			divisor_q     <= DIVISOR_RESET;
		end else begin
			if (wr_lf) begin
				line_format_q <= w_data_q; // RULE10 RULE11 RULE13 RULE14 RULE15
			end
			if (wr_hc) begin
				handshake_q <= w_data_q[HC_W-1:0]; // RULE20
			end
			if (wr_ier) begin
				irq_enable_q <= w_data_q[IE_W-1:0];
			end
			if (wr_dll) begin
				divisor_q[7:0] <= w_data_q;
			end
			if (wr_dlm) begin
				divisor_q[15:8] <= w_data_q;
			end
		end
	end

	// Identification and pending flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_identify_q <= {2'b00, 2'b00, ID_NONE};
			thre_pend_q    <= 1'b0;
			thre_src_q     <= 1'b0;
			timeout_q      <= 1'b0;
			idle_cnt_q     <= 10'h000;
		end else begin
			if (!iir_frozen) begin
				irq_identify_q <= id_next; // RULE26
			end
			thre_src_q <= thr_empty & irq_enable_q[IE_THR_EMPTY];
			// Fresh empty edge wins over a same-cycle clear
			if (thr_empty & irq_enable_q[IE_THR_EMPTY] & ~thre_src_q) begin
				thre_pend_q <= 1'b1;
			end else if (thre_named | wr_thr) begin
				thre_pend_q <= 1'b0; // RULE9
			end
			if (idle_event) begin
				idle_cnt_q <= 10'h000;
			end else if (baud16_tick & ~idle_done) begin
				idle_cnt_q <= idle_cnt_q + 10'h001;
			end
			if (idle_done & ~idle_event) begin
				timeout_q <= 1'b1; // RULE7
			end else if (rx_read_q | ~fifo_enable) begin
				timeout_q <= 1'b0; // RULE7
			end
		end
	end

	// Side pulses toward the receive and transmit buffers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_read_q   <= 1'b0;
			thr_write_q <= 1'b0;
			thr_data_q  <= 8'h00;
		end else begin
			rx_read_q   <= rd_rbr;
			thr_write_q <= wr_thr;
			if (wr_thr) begin
				thr_data_q <= w_data_q;
			end
		end
	end

	assign rx_buffer_read = rx_read_q;
	assign thr_write      = thr_write_q;
	assign thr_data       = thr_data_q;
	assign divisor        = divisor_q;

	// Receiver samples one stop bit only; it is told the format, not the count
	assign line_cfg = '{
		break_on:  line_format_q[LF_BREAK],
		stick:     line_format_q[LF_STICK],
		even:      line_format_q[LF_EVEN],
		parity_en: line_format_q[LF_PAR_EN],
		two_stop:  line_format_q[LF_STOP],
		word_len:  line_format_q[LF_LEN_LSB +: 2]
	}; // RULE12

	// Break overrides everything, including loopback marking
	assign serial_out  = line_format_q[LF_BREAK] ? 1'b0 : (loopback ? 1'b1 : tx_shift_out); // RULE16 RULE22
	assign rx_shift_in = loopback ? tx_shift_out : serial_in; // RULE22

	assign terminal_ready_n = loopback ? 1'b1 : ~handshake_q[HC_TERM_READY]; // RULE19 RULE23
	assign send_request_n   = loopback ? 1'b1 : ~handshake_q[HC_SEND_REQ]; // RULE19 RULE23
	assign modem_status = loopback ? '{
		carrier:       handshake_q[HC_IRQ_GATE],
		ring:          handshake_q[HC_AUX_ONE],
		set_ready:     handshake_q[HC_TERM_READY],
		clear_to_send: handshake_q[HC_SEND_REQ]
	} : '{
		carrier:       ~carrier_detect_n,
		ring:          ~ring_indicate_n,
		set_ready:     ~set_ready_n,
		clear_to_send: ~clear_to_send_n
	}; // RULE23 RULE24

	// Output enable low models the high-impedance state
	assign irq_out = ~irq_identify_q[0];
	assign irq_oe  = handshake_q[HC_IRQ_GATE]; // RULE21

endmodule // uart_irq_line_modem
`default_nettype wire

// ---- tb/modem_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module modem_partner #(
	parameter int SLOW = 1
) (
	input wire logic	clk,
	input wire logic	reset_n,
	input wire logic	terminal_ready_n,
	input wire logic	send_request_n,
	input wire logic [1:0]	line_req,
	output logic		clear_to_send_n,
	output logic		set_ready_n,
	output logic		ring_indicate_n,
	output logic		carrier_detect_n,
	output logic		serial_in
);
	logic [7:0]	pat_q;
	logic		cts_q;
	logic		dsr_q;
	// No frames sent; a moving pattern keeps a stale level from passing as data
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pat_q <= 8'h5b;
			cts_q <= 1'b1;
			dsr_q <= 1'b1;
		end else begin
			pat_q <= {pat_q[6:0], ~pat_q[7]};
			cts_q <= send_request_n;
			dsr_q <= terminal_ready_n;
		end
	end
	// Slow modem answers handshake one cycle late
	assign clear_to_send_n = (SLOW != 0) ? cts_q : send_request_n;
	assign set_ready_n = (SLOW != 0) ? dsr_q : terminal_ready_n;
	assign ring_indicate_n = ~line_req[0];
	assign carrier_detect_n = ~line_req[1];
	assign serial_in = pat_q[0];
endmodule // modem_partner
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import uart_ctrl_pkg::*;
	logic		clk = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic		s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fifo_enable = 1'b0, rx_push = 1'b0, thr_empty = 1'b0;
	logic		line_status_event = 1'b0, modem_delta = 1'b0, baud16_tick = 1'b0, tx_shift_out = 1'b1;
	logic [5:0]	s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0]	s_axi_wdata = 32'h0;
	logic [3:0]	s_axi_wstrb = 4'h1;
	logic [1:0]	rx_trigger_sel = 2'h0, line_req = 2'h0, s_axi_bresp, s_axi_rresp;
	logic [4:0]	rx_level = 5'h00;
	logic [7:0]	rx_buffer_data = 8'h00, thr_data;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_buffer_read, thr_write;
	logic		rx_shift_in, serial_out, serial_in, terminal_ready_n, send_request_n, irq_out, irq_oe;
	logic		clear_to_send_n, set_ready_n, ring_indicate_n, carrier_detect_n;
	logic [31:0]	s_axi_rdata;
	logic [15:0]	divisor;
	line_cfg_s	line_cfg;
	modem_s		modem_status;
	logic [7:0]	lf [4] = '{8'h40, 8'h3b, 8'h04, 8'h1e};
	int		err_count = 0, total_checks = 0;
	uart_irq_line_modem dut (.*);
	modem_partner #(.SLOW(1)) peer (.*);
	always #25 clk = ~clk;
	always @(posedge clk) tx_shift_out <= 1'($urandom);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	function automatic logic [7:0] ident(input logic f, input logic [3:0] c);
		return {f, f, 2'b00, c};
	endfunction
	// A leading edge keeps a release and the next request out of one time step
	task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		check(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rdc(input logic [3:0] idx, input logic [7:0] e, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, {24'h0, e});
		check(32'(s_axi_rresp), 32'(er));
	endtask
	initial begin
		#(5000 * 50);
		err_count++;
		conclude();
	end
	initial begin
		logic [7:0] v;
		logic [7:0] u;
		void'($urandom(83));
		rx_buffer_data <= 8'($urandom);
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rdc(IDX_IRQ_IDENTIFY, 8'h01, AXI_OKAY);
		rdc(4'h7, 8'h00, AXI_SLVERR);
		wr(IDX_IRQ_IDENTIFY, 8'hff, AXI_SLVERR);
		for (int i = 0; i < 12; i++) begin
			v = (i < 4) ? lf[i] : 8'($urandom) & 8'h7f;
			u = (i < 2) ? (i == 0 ? 8'hff : 8'h1f) : 8'($urandom);
			line_req <= 2'($urandom);
			wr(IDX_LINE_FORMAT, v, AXI_OKAY);
			check(line_cfg, v[6:0]);
			rdc(IDX_LINE_FORMAT, v, AXI_OKAY);
			wr(IDX_HANDSHAKE, u, AXI_OKAY);
			rdc(IDX_HANDSHAKE, u & 8'h1f, AXI_OKAY);
			check({terminal_ready_n, send_request_n}, u[4] ? 2'b11 : {~u[0], ~u[1]});
			check(modem_status, u[4] ? {u[3], u[2], u[0], u[1]} : {line_req, u[0], u[1]});
			check(irq_oe, u[3]);
		end
		wr(IDX_HANDSHAKE, 8'h08, AXI_OKAY);
		wr(IDX_LINE_FORMAT, 8'h83, AXI_OKAY);
		wr(IDX_DATA, 8'h34, AXI_OKAY);
		wr(IDX_IRQ_ENABLE, 8'h12, AXI_OKAY);
		check(divisor, 16'h1234);
		rdc(IDX_DATA, 8'h34, AXI_OKAY);
		wr(IDX_LINE_FORMAT, 8'h03, AXI_OKAY);
		wr(IDX_IRQ_ENABLE, 8'h0f, AXI_OKAY);
		rdc(IDX_IRQ_ENABLE, 8'h0f, AXI_OKAY);
		rdc(IDX_DATA, rx_buffer_data, AXI_OKAY);
		check(rx_buffer_read, 1'b1);
		line_status_event <= 1'b1;
		rx_level <= 5'h01;
		modem_delta <= 1'b1;
		thr_empty <= 1'b1;
		rdc(IDX_IRQ_IDENTIFY, ident(1'b0, ID_LINE_STATUS), AXI_OKAY);
		check(irq_out, 1'b1);
		line_status_event <= 1'b0;
		rdc(IDX_IRQ_IDENTIFY, ident(1'b0, ID_RX_DATA), AXI_OKAY);
		rx_level <= 5'h00;
		rdc(IDX_IRQ_IDENTIFY, ident(1'b0, ID_THR_EMPTY), AXI_OKAY);
		rdc(IDX_IRQ_IDENTIFY, ident(1'b0, ID_MODEM), AXI_OKAY);
		modem_delta <= 1'b0;
		rdc(IDX_IRQ_IDENTIFY, ident(1'b0, ID_NONE), AXI_OKAY);
		thr_empty <= 1'b0;
		@(posedge clk);
		thr_empty <= 1'b1;
		// Pending flag needs one edge before the code can show it
		@(posedge clk);
		rdc(IDX_IRQ_IDENTIFY, ident(1'b0, ID_THR_EMPTY), AXI_OKAY);
		thr_empty <= 1'b0;
		@(posedge clk);
		thr_empty <= 1'b1;
		wr(IDX_DATA, rx_buffer_data ^ 8'ha5, AXI_OKAY);
		check(thr_write, 1'b1);
		check(thr_data, rx_buffer_data ^ 8'ha5);
		rdc(IDX_IRQ_IDENTIFY, ident(1'b0, ID_NONE), AXI_OKAY);
		fifo_enable <= 1'b1;
		rx_trigger_sel <= 2'h1;
		rx_level <= 5'h03;
		rdc(IDX_IRQ_IDENTIFY, ident(1'b1, ID_NONE), AXI_OKAY);
		rx_level <= 5'h04;
		rdc(IDX_IRQ_IDENTIFY, ident(1'b1, ID_RX_DATA), AXI_OKAY);
		rx_level <= 5'h01;
		baud16_tick <= 1'b1;
		repeat (400) @(posedge clk);
		rdc(IDX_IRQ_IDENTIFY, ident(1'b1, ID_NONE), AXI_OKAY);
		repeat (600) @(posedge clk);
		rdc(IDX_IRQ_IDENTIFY, ident(1'b1, ID_CHAR_TIMEOUT), AXI_OKAY);
		rdc(IDX_DATA, rx_buffer_data, AXI_OKAY);
		rdc(IDX_IRQ_IDENTIFY, ident(1'b1, ID_NONE), AXI_OKAY);
		fifo_enable <= 1'b0;
		rdc(IDX_IRQ_IDENTIFY, ident(1'b0, ID_RX_DATA), AXI_OKAY);
		reset_n <= 1'b0;
		@(posedge clk);
		reset_n <= 1'b1;
		rdc(IDX_LINE_FORMAT, 8'h00, AXI_OKAY);
		conclude();
	end
endmodule // testbench
bind uart_irq_line_modem uart_irq_line_modem_asserts chk (.*);
`default_nettype wire

// ---- tb/uart_irq_line_modem_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module uart_irq_line_modem_asserts (
	input wire logic				clk,
	input wire logic				reset_n,
	input wire logic [uart_ctrl_pkg::ADDR_W-1:0]	s_axi_awaddr,
	input wire logic				s_axi_awvalid,
	input wire logic				s_axi_awready,
	input wire logic [31:0]				s_axi_wdata,
	input wire logic [3:0]				s_axi_wstrb,
	input wire logic				s_axi_wvalid,
	input wire logic				s_axi_wready,
	input wire logic				s_axi_bvalid,
	input wire logic				s_axi_arvalid,
	input wire logic				s_axi_arready,
	input wire logic [31:0]				s_axi_rdata,
	input wire logic				s_axi_rvalid,
	input wire logic				s_axi_rready,
	input wire uart_ctrl_pkg::line_cfg_s		line_cfg,
	input wire logic				tx_shift_out,
	input wire logic				rx_shift_in,
	input wire logic				serial_out,
	input wire logic				serial_in,
	input wire logic				terminal_ready_n,
	input wire logic				send_request_n,
	input wire logic				clear_to_send_n,
	input wire logic				set_ready_n,
	input wire logic				ring_indicate_n,
	input wire logic				carrier_detect_n,
	input wire uart_ctrl_pkg::modem_s		modem_status,
	input wire logic				irq_oe
);
	import uart_ctrl_pkg::*;
	logic [3:0]	idx_q;
	logic [7:0]	wd_q;
	logic		ws_q;
	logic		bv_q;
	logic [4:0]	hc_q;
	// Shadow of handshake control; new value counts from the first response cycle
	wire		first_b = s_axi_bvalid && !bv_q;
	wire [4:0]	hc = (first_b && idx_q == IDX_HANDSHAKE && ws_q) ? wd_q[4:0] : hc_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_q <= 4'h0;
			wd_q <= 8'h00;
			ws_q <= 1'b0;
			bv_q <= 1'b0;
			hc_q <= 5'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				idx_q <= s_axi_awaddr[5:2];
			if (s_axi_wvalid && s_axi_wready)
				wd_q <= s_axi_wdata[7:0];
			if (s_axi_wvalid && s_axi_wready)
				ws_q <= s_axi_wstrb[0];
			bv_q <= s_axi_bvalid;
			hc_q <= hc;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_break_spaces: assert property (line_cfg.break_on |-> !serial_out) else $error("break not spacing");
	a_loop_marks: assert property (hc[4] && !line_cfg.break_on |-> serial_out) else $error("loopback not marking");
	a_tx_path: assert property (!hc[4] && !line_cfg.break_on |-> serial_out == tx_shift_out) else $error("tx path");
	a_rx_source: assert property (rx_shift_in == (hc[4] ? tx_shift_out : serial_in)) else $error("rx source");
	a_ctrl_pins: assert property ({terminal_ready_n, send_request_n} == (hc[4] ? 2'b11 : {~hc[0], ~hc[1]}))
		else $error("control pins");
	a_loop_status: assert property (hc[4] |-> modem_status == {hc[3], hc[2], hc[0], hc[1]})
		else $error("loop status");
	a_pin_status: assert property (!hc[4] |-> modem_status == ~{carrier_detect_n, ring_indicate_n, set_ready_n,
		clear_to_send_n}) else $error("pin status");
	a_irq_gate: assert property (irq_oe == hc[3]) else $error("irq gate");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
		else $error("read answer");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	cover property (line_cfg.break_on && hc[4]);
	cover property (hc[4] && hc[3]);
	cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[0] == 1'b0);
endmodule // uart_irq_line_modem_asserts
`default_nettype wire
